// ===== pic_pkg.sv
// Constants, source tables and carrier types for the priority interrupt controller.
// Assumes a CPU core that takes one request at a time and signals each return from service.
// Contract
// - Up to twelve sources, each enabled by its own bit across two enable registers.
// - One global enable bit in the first enable register blocks all sources.
// - Every source carries one of four programmable priority levels.
// - Level comes from same-position bits of high and low priority registers, two banks.
// - A routine is preempted only by strictly higher level; top level never.
// - Simultaneous requests of different levels: the higher level is served.
// - Equal-level ties go to fixed rank one to thirteen, external zero first.
// - Each source branches to its own fixed vector address.
// - Only externals, brownout, keypad, comparators and watchdog wake from power-down.
// - Trigger-type clear: external request active while its pin samples low.
// - Trigger-type set: flag sets when one sample is high and next low.
// - Edge mode: flag clears automatically when the CPU vectors to that routine.
// - Level mode: request held until taken; still active after return retriggers.
// - Level mode: flag follows the pin directly, no software clear needed.
// - An enabled external request wakes the processor from idle or power-down.
package pic_pkg;

   localparam int NUM_SRC = 12;
   localparam int NUM_LEVELS = 4;
   localparam int NUM_EXT = 2;
   localparam int CLK_PERIOD_NS = 5;
   localparam int MACHINE_CYCLE_CLKS = 6;
   localparam logic [2:0] MC_LAST = 3'(MACHINE_CYCLE_CLKS - 1);
   localparam int GLOBAL_EN_BIT = 7;

   // Source indices in table order.
   localparam logic [3:0] SRC_EXT0 = 4'h0;
   localparam logic [3:0] SRC_EXT1 = 4'h2;
   localparam logic [1:0][3:0] EXT_SRC = {SRC_EXT1, SRC_EXT0};

   // Register bank per source: one selects the second enable and priority bank.
   localparam logic [11:0] SRC_BANK_B = 12'hdc0;
   // Bit position within the bank, index eleven first.
   localparam logic [11:0][2:0] SRC_BIT = {3'h7, 3'h5, 3'h6, 3'h2, 3'h1, 3'h0,
                                           3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
   localparam logic [11:0][3:0] SRC_RANK = {4'hd, 4'h9, 4'h3, 4'hb, 4'h8, 4'h5,
                                            4'h2, 4'hc, 4'ha, 4'h7, 4'h4, 4'h1};
   localparam logic [11:0][15:0] SRC_VECTOR = {16'h0073, 16'h0063, 16'h0053, 16'h0043,
                                               16'h003b, 16'h0033, 16'h002b, 16'h0023,
                                               16'h001b, 16'h0013, 16'h000b, 16'h0003};
   localparam logic [11:0] SRC_WAKE = 12'h7a5;

   localparam logic [2:0] SYNC_RESET = 3'h7;
   localparam logic [3:0] IN_SERVICE_RESET = 4'h0;

   typedef struct packed {
      logic valid;
      logic [1:0] level;
      logic [3:0] src;
      logic [15:0] vector;
   } pic_req_t;

   localparam pic_req_t REQ_RESET = '{valid: 1'b0, level: 2'h0, src: 4'h0, vector: 16'h0000};

endpackage : pic_pkg

// ===== pic_ext_irq.sv
// External request input: pin synchroniser, machine-cycle sampler and request flag.
// Assumes the pin is active low and asynchronous, and sample_i pulses once per machine cycle.
`timescale 1ns/1ps
module pic_ext_irq (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic pin_n_i,
   input wire logic sample_i,
   input wire logic edge_mode_i,
   input wire logic ack_i,
   output logic flag_o
);

   logic [2:0] sync;
   logic pin_stable;
   logic pin_sample;
   logic fell;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync <= pic_pkg::SYNC_RESET;
      end else begin
         sync <= {sync[1:0], pin_n_i};
      end
   end

   // A pin change is accepted only once the second and third stages agree.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_stable <= 1'b1;
      end else if (sync[1] == sync[2]) begin
         pin_stable <= sync[2];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_sample <= 1'b1;
      end else if (sample_i) begin
         pin_sample <= pin_stable;
      end
   end

   assign fell = sample_i && pin_sample && !pin_stable;

   // In edge mode a new edge beats a clear in the same cycle.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flag_o <= 1'b0;
      end else if (edge_mode_i) begin
         if (fell) begin
            flag_o <= 1'b1;
         end else if (ack_i) begin
            flag_o <= 1'b0;
         end
      end else begin
         flag_o <= !pin_sample;
      end
   end

   chk_edge_sets: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      edge_mode_i && fell |=> flag_o)
      else $error("edge flag not set after falling sample");

   chk_ack_clears: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      edge_mode_i && ack_i && !fell |=> !flag_o)
      else $error("edge flag not cleared by vectoring");

   chk_level_tracks: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      !edge_mode_i |=> flag_o == !$past(pin_sample))
      else $error("level flag does not follow the pin");

endmodule : pic_ext_irq

// ===== pic_core.sv
// Priority interrupt controller: enables, four-level priority, nesting, vector and wake-up.
// Assumes peripheral flags are synchronous to clk_i and are cleared by their own blocks.
// The CPU pulses irq_ack_i when it vectors to the presented request and irq_return_i on return.
`timescale 1ns/1ps
module pic_core #(
   parameter int NUM_SRC = pic_pkg::NUM_SRC
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] irq_enable_reg_a_i,
   input wire logic [7:0] irq_enable_reg_b_i,
   input wire logic [7:0] prio_low_bank_a_i,
   input wire logic [7:0] prio_high_bank_a_i,
   input wire logic [7:0] prio_low_bank_b_i,
   input wire logic [7:0] prio_high_bank_b_i,
   input wire logic [1:0] ext_trigger_type_i,
   input wire logic [1:0] ext_request_pin_n_i,
   input wire logic timer0_flag_i,
   input wire logic timer1_flag_i,
   input wire logic serial_flag_i,
   input wire logic brownout_flag_i,
   input wire logic i2c_attention_flag_i,
   input wire logic keypad_flag_i,
   input wire logic comparator_two_flag_i,
   input wire logic watchdog_overflow_flag_i,
   input wire logic comparator_one_flag_i,
   input wire logic bus_timer_flag_i,
   input wire logic irq_ack_i,
   input wire logic irq_return_i,
   output pic_pkg::pic_req_t irq_o,
   output logic [3:0] in_service_o,
   output logic [1:0] ext_request_flag_o,
   output logic wake_o
);

   // Returns {active, level} of the highest level currently in service.
   function automatic logic [2:0] top_level(input logic [3:0] isv);
      logic [2:0] res;
      res = 3'h0;
      for (int k = 0; k < pic_pkg::NUM_LEVELS; k++) begin
         if (isv[k]) begin
            res = {1'b1, k[1:0]};
         end
      end
      return res;
   endfunction : top_level

   // Picks a source's bit from whichever of the two banks holds it.
   function automatic logic bank_bit(input logic [7:0] bank_a, input logic [7:0] bank_b, input int idx);
      logic [2:0] pos;
      pos = pic_pkg::SRC_BIT[idx];
      return pic_pkg::SRC_BANK_B[idx] ? bank_b[pos] : bank_a[pos];
   endfunction : bank_bit

   logic [2:0] mc_cnt;
   logic mc_tick;
   logic [1:0] ext_flag;
   logic [1:0] ext_ack;
   logic [NUM_SRC-1:0] src_flag;
   logic [NUM_SRC-1:0] src_en;
   logic [NUM_SRC-1:0][1:0] src_lvl;
   logic [NUM_SRC-1:0] eligible;
   logic global_irq_enable;
   logic best_found;
   logic [1:0] best_level;
   logic [3:0] best_rank;
   logic [3:0] best_src;
   logic [2:0] cur_top;
   logic preempt_ok;
   logic taken;
   pic_pkg::pic_req_t next_irq;
   logic [3:0] next_in_service;

   // Machine-cycle strobe: one pulse every six CPU clocks.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mc_cnt <= 3'h0;
      end else if (mc_cnt == pic_pkg::MC_LAST) begin
         mc_cnt <= 3'h0;
      end else begin
         mc_cnt <= mc_cnt + 3'h1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mc_tick <= 1'b0;
      end else begin
         mc_tick <= (mc_cnt == pic_pkg::MC_LAST);
      end
   end

   assign taken = irq_ack_i && irq_o.valid;

   generate
      for (genvar e = 0; e < pic_pkg::NUM_EXT; e++) begin : g_ext
         assign ext_ack[e] = taken && (irq_o.src == pic_pkg::EXT_SRC[e]);
         pic_ext_irq u_ext (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .pin_n_i(ext_request_pin_n_i[e]),
            .sample_i(mc_tick),
            .edge_mode_i(ext_trigger_type_i[e]),
            .ack_i(ext_ack[e]),
            .flag_o(ext_flag[e])
         );
      end
   endgenerate

   assign ext_request_flag_o = ext_flag;

   assign src_flag = {bus_timer_flag_i, comparator_one_flag_i, watchdog_overflow_flag_i,
                      comparator_two_flag_i, keypad_flag_i, i2c_attention_flag_i,
                      brownout_flag_i, serial_flag_i, timer1_flag_i, ext_flag[1],
                      timer0_flag_i, ext_flag[0]};

   assign global_irq_enable = irq_enable_reg_a_i[pic_pkg::GLOBAL_EN_BIT];

   generate
      for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
         assign src_en[g] = bank_bit(irq_enable_reg_a_i, irq_enable_reg_b_i, g);
         assign src_lvl[g] = {bank_bit(prio_high_bank_a_i, prio_high_bank_b_i, g),
                              bank_bit(prio_low_bank_a_i, prio_low_bank_b_i, g)};
         assign eligible[g] = src_flag[g] && src_en[g] && global_irq_enable;
      end
   endgenerate

   // Highest level wins; the fixed rank only breaks ties within one level.
   always_comb begin
      best_found = 1'b0;
      best_level = 2'h0;
      best_rank = 4'hf;
      best_src = 4'h0;
      for (int i = 0; i < NUM_SRC; i++) begin
         if (eligible[i] && (!best_found || (src_lvl[i] > best_level) ||
             ((src_lvl[i] == best_level) && (pic_pkg::SRC_RANK[i] < best_rank)))) begin
            best_found = 1'b1;
            best_level = src_lvl[i];
            best_rank = pic_pkg::SRC_RANK[i];
            best_src = i[3:0];
         end
      end
   end

   assign cur_top = top_level(in_service_o);
   // Nothing exceeds level three, so a routine at the top level is never preempted.
   assign preempt_ok = !cur_top[2] || (best_level > cur_top[1:0]);

   // The request drops in the cycle after it is taken, so a stale pick is never shown again.
   always_comb begin
      next_irq = pic_pkg::REQ_RESET;
      if (!taken && best_found && preempt_ok) begin
         next_irq.valid = 1'b1;
         next_irq.level = best_level;
         next_irq.src = best_src;
         next_irq.vector = pic_pkg::SRC_VECTOR[best_src];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_o <= pic_pkg::REQ_RESET;
      end else begin
         irq_o <= next_irq;
      end
   end

   // One in-service bit per level; return clears the highest, uncovering the preempted level.
   always_comb begin
      next_in_service = in_service_o;
      if (taken) begin
         next_in_service[irq_o.level] = 1'b1;
      end else if (irq_return_i && cur_top[2]) begin
         next_in_service[cur_top[1:0]] = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         in_service_o <= pic_pkg::IN_SERVICE_RESET;
      end else begin
         in_service_o <= next_in_service;
      end
   end

   // Wake-up needs an enabled, pending source that may end power-down.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wake_o <= 1'b0;
      end else begin
         wake_o <= |(eligible & pic_pkg::SRC_WAKE);
      end
   end

   // Helper logic read only by the checks below.
   logic [3:0] chk_pop_mask;
   always_comb begin
      chk_pop_mask = 4'hf;
      if (cur_top[2]) begin
         chk_pop_mask[cur_top[1:0]] = 1'b0;
      end
   end

   sequence s_tick_gap;
      !mc_tick [*5] ##1 mc_tick;
   endsequence

   // The taken level is read one cycle back, because the request has already dropped to its reset value.
   sequence s_taken_then_bit(logic [1:0] lvl);
      ##1 (in_service_o[$past(lvl)] && !irq_o.valid);
   endsequence

   sequence s_return_pop;
      irq_return_i && !taken && cur_top[2];
   endsequence

   chk_machine_cycle: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      mc_tick |=> s_tick_gap)
      else $error("machine-cycle strobe period is not six clocks");

   chk_global_disable: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      !global_irq_enable |=> !irq_o.valid)
      else $error("request shown while globally disabled");

   chk_strict_preempt: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      irq_o.valid |-> (!cur_top[2] || (irq_o.level > cur_top[1:0])))
      else $error("request does not exceed the level in service");

   chk_top_level_hold: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      in_service_o[3] |=> !irq_o.valid)
      else $error("top-level routine was offered a preemption");

   chk_highest_wins: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      irq_o.valid |-> (irq_o.level == $past(best_level)))
      else $error("presented level is not the highest pending");

   chk_tie_rank: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      irq_o.valid |-> (pic_pkg::SRC_RANK[irq_o.src] == $past(best_rank)))
      else $error("tie not resolved by fixed rank");

   chk_vector_map: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      irq_o.valid |-> (irq_o.vector == pic_pkg::SRC_VECTOR[irq_o.src]))
      else $error("vector does not match the source");

   chk_wake_sources: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      wake_o |-> $past(|(eligible & pic_pkg::SRC_WAKE)))
      else $error("wake-up from a source that may not wake");

   chk_ack_nesting: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      taken |-> s_taken_then_bit(irq_o.level))
      else $error("taken level not marked in service");

   chk_return_restore: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      irq_return_i && !taken |=> (in_service_o == ($past(in_service_o) & $past(chk_pop_mask))))
      else $error("return did not restore the previous level");

   chk_return_clears_top: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      s_return_pop |=> !in_service_o[$past(cur_top[1:0])])
      else $error("return left the top level in service");

   chk_take_new_level: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      taken |-> !in_service_o[irq_o.level])
      else $error("taken level was already in service");

   chk_pending_shown: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      best_found && !cur_top[2] && !taken |=> irq_o.valid)
      else $error("pending request not presented while idle");

   chk_idle_quiet: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      !(|eligible) |=> !irq_o.valid)
      else $error("request shown with no eligible source");

   chk_wake_blocked: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      !global_irq_enable |=> !wake_o)
      else $error("wake-up raised while globally disabled");

   chk_tick_bound: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      mc_cnt <= pic_pkg::MC_LAST)
      else $error("machine-cycle counter out of range");

endmodule : pic_core

// ===== pic_cpu_model.sv
// Behavioural CPU core facing the interrupt controller: takes presented requests and signals returns.
// Assumes it shares the controller's clock and reset; the bench steers when it may take a request.
`timescale 1ns/1ps
module pic_cpu_model (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire pic_pkg::pic_req_t irq_i,
   input wire logic ack_en_i,
   input wire logic [1:0] delay_i,
   input wire logic ret_req_i,
   output logic ack_o,
   output logic return_o,
   output logic [7:0] taken_cnt_o,
   output logic [15:0] taken_vector_o
);
   logic [1:0] wait_cnt;

   // The ack is held one cycle and counts only if a request still stands at that edge.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_o <= 1'b0;
         wait_cnt <= 2'h0;
         taken_cnt_o <= 8'h00;
         taken_vector_o <= 16'h0000;
      end else if (ack_o) begin
         ack_o <= 1'b0;
         wait_cnt <= 2'h0;
         if (irq_i.valid) begin
            taken_cnt_o <= taken_cnt_o + 8'h01;
            taken_vector_o <= irq_i.vector;
         end
      end else if (irq_i.valid && ack_en_i) begin
         if (wait_cnt == delay_i) begin
            ack_o <= 1'b1;
         end else begin
            wait_cnt <= wait_cnt + 2'h1;
         end
      end else begin
         wait_cnt <= 2'h0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         return_o <= 1'b0;
      end else begin
         return_o <= ret_req_i;
      end
   end
endmodule : pic_cpu_model

// ===== pic_core_tb.sv
// Self-checking bench for the interrupt controller with a behavioural CPU on its service side.
// Assumes the bench stands in for peripherals and external pins, holding pins a dozen clocks or more.
`timescale 1ns/1ps
module pic_core_tb;
   localparam int LIMIT = 20000;
   localparam int POS[12] = '{0, 1, 2, 3, 4, 5, 0, 1, 2, 6, 5, 7};
   localparam int RANK[12] = '{1, 4, 7, 10, 12, 2, 5, 8, 11, 3, 9, 13};
   localparam logic [11:0] BANKB = 12'h0dc0;
   localparam logic [11:0] WAKE = 12'h07a5;
   localparam logic [15:0] VEC[12] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b,
                                       16'h0033, 16'h003b, 16'h0043, 16'h0053, 16'h0063, 16'h0073};
   logic clk_i, rst_n_i, ack_en, ret_req, ack, ret_pulse, wake;
   logic [7:0] en_a, en_b, pl_a, ph_a, pl_b, ph_b, taken_cnt;
   logic [1:0] trig, pins, ext_flag, ack_delay;
   logic [11:0] flags;
   logic [3:0] in_service;
   logic [15:0] taken_vec;
   pic_pkg::pic_req_t irq;
   int err_count, checked, cycles;

   pic_core uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .irq_enable_reg_a_i(en_a), .irq_enable_reg_b_i(en_b),
      .prio_low_bank_a_i(pl_a), .prio_high_bank_a_i(ph_a), .prio_low_bank_b_i(pl_b), .prio_high_bank_b_i(ph_b),
      .ext_trigger_type_i(trig), .ext_request_pin_n_i(pins), .timer0_flag_i(flags[1]),
      .timer1_flag_i(flags[3]), .serial_flag_i(flags[4]), .brownout_flag_i(flags[5]),
      .i2c_attention_flag_i(flags[6]), .keypad_flag_i(flags[7]), .comparator_two_flag_i(flags[8]),
      .watchdog_overflow_flag_i(flags[9]), .comparator_one_flag_i(flags[10]), .bus_timer_flag_i(flags[11]),
      .irq_ack_i(ack), .irq_return_i(ret_pulse), .irq_o(irq), .in_service_o(in_service),
      .ext_request_flag_o(ext_flag), .wake_o(wake));

   pic_cpu_model cpu (.clk_i(clk_i), .rst_n_i(rst_n_i), .irq_i(irq), .ack_en_i(ack_en), .delay_i(ack_delay),
      .ret_req_i(ret_req), .ack_o(ack), .return_o(ret_pulse), .taken_cnt_o(taken_cnt),
      .taken_vector_o(taken_vec));

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   task automatic results();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : results

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == LIMIT) begin
         err_count++;
         results();
      end
   end

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : cyc

   task automatic set_src(input int i, input logic en, input logic [1:0] lvl);
      if (BANKB[i]) begin
         en_b[POS[i]] = en;
         ph_b[POS[i]] = lvl[1];
         pl_b[POS[i]] = lvl[0];
      end else begin
         en_a[POS[i]] = en;
         ph_a[POS[i]] = lvl[1];
         pl_a[POS[i]] = lvl[0];
      end
   endtask : set_src

   task automatic set_req(input int i, input logic v);
      if (i == 0) pins[0] = ~v;
      else if (i == 2) pins[1] = ~v;
      else flags[i] = v;
      cyc(14);
   endtask : set_req

   task automatic wait_irq(input logic exp);
      int n;
      n = 0;
      while (irq.valid !== exp && n < 40) begin
         cyc(1);
         n++;
      end
      check("irq_valid", 16'(irq.valid), 16'(exp));
   endtask : wait_irq

   task automatic serve();
      logic [7:0] c;
      int n;
      c = taken_cnt;
      n = 0;
      ack_en = 1'b1;
      while (taken_cnt === c && n < 20) begin
         cyc(1);
         n++;
      end
      ack_en = 1'b0;
      cyc(1);
      check("served", 16'(taken_cnt - c), 16'h0001);
   endtask : serve

   task automatic ret();
      ret_req = 1'b1;
      cyc(1);
      ret_req = 1'b0;
      cyc(3);
   endtask : ret

   initial begin
      {ack_en, ret_req, ack_delay, trig, flags, cycles, err_count, checked} = '0;
      {en_a, en_b, pl_a, ph_a, pl_b, ph_b} = '0;
      pins = 2'b11;
      rst_n_i = 1'b0;
      cyc(5);
      rst_n_i = 1'b1;
      en_a[7] = 1'b1;
      for (int i = 0; i < 12; i++) begin
         set_src(i, 1'b1, 2'(i % 4));
         set_req(i, 1'b1);
         wait_irq(1'b1);
         check("vector", irq.vector, VEC[i]);
         check("level", 16'(irq.level), 16'(i % 4));
         check("wake", 16'(wake), 16'(WAKE[i]));
         en_a[7] = 1'b0;
         wait_irq(1'b0);
         en_a[7] = 1'b1;
         wait_irq(1'b1);
         serve();
         check("taken_vector", taken_vec, VEC[i]);
         check("in_service", 16'(in_service), 16'(1 << (i % 4)));
         set_req(i, 1'b0);
         ret();
         check("in_service", 16'(in_service), 16'h0000);
         set_src(i, 1'b0, 2'h0);
      end
      $display("test sources done");
      for (int i = 0; i < 12; i++) begin
         set_src(i, 1'b1, 2'h1);
         flags[i] = 1'b1;
      end
      pins = 2'b00;
      set_src(11, 1'b1, 2'h2);
      cyc(14);
      check("high_src", 16'(irq.src), 16'h000b);
      set_src(11, 1'b1, 2'h1);
      for (int r = 1; r <= 13; r++) for (int i = 0; i < 12; i++) if (RANK[i] == r) begin
         cyc(2);
         check("tie_src", 16'(irq.src), 16'(i));
         set_src(i, 1'b0, 2'h1);
      end
      wait_irq(1'b0);
      flags = '0;
      pins = 2'b11;
      $display("test ranking done");
      ack_delay = 2'h3;
      set_src(1, 1'b1, 2'h1);
      set_req(1, 1'b1);
      serve();
      set_src(11, 1'b1, 2'h1);
      set_req(11, 1'b1);
      check("same_level", 16'(irq.valid), 16'h0000);
      set_src(11, 1'b1, 2'h3);
      wait_irq(1'b1);
      serve();
      check("nested", 16'(in_service), 16'h000a);
      set_src(5, 1'b1, 2'h3);
      set_req(5, 1'b1);
      check("top_level", 16'(irq.valid), 16'h0000);
      set_req(11, 1'b0);
      ret();
      wait_irq(1'b1);
      check("resumed_src", 16'(irq.src), 16'h0005);
      check("restored", 16'(in_service), 16'h0002);
      serve();
      set_req(5, 1'b0);
      ret();
      check("restored", 16'(in_service), 16'h0002);
      set_req(1, 1'b0);
      ret();
      check("restored", 16'(in_service), 16'h0000);
      $display("test nesting done");
      ack_delay = 2'h0;
      trig = 2'b01;
      set_src(0, 1'b1, 2'h2);
      check("edge_idle", 16'(ext_flag[0]), 16'h0000);
      set_req(0, 1'b1);
      check("edge_flag", 16'(ext_flag[0]), 16'h0001);
      serve();
      cyc(2);
      check("edge_clear", 16'(ext_flag[0]), 16'h0000);
      check("edge_once", 16'(irq.valid), 16'h0000);
      ret();
      set_req(0, 1'b0);
      set_src(2, 1'b1, 2'h2);
      set_req(2, 1'b1);
      check("level_flag", 16'(ext_flag[1]), 16'h0001);
      serve();
      ret();
      wait_irq(1'b1);
      set_req(2, 1'b0);
      check("level_flag", 16'(ext_flag[1]), 16'h0000);
      wait_irq(1'b0);
      $display("test external done");
      results();
   end
endmodule : pic_core_tb
